// File: common/bssp_pkg.sv
// package of constants and carriers for the buffered synchronous serial port
// Function
// - serial out select routes data pin
// - open drain and chip select options
// - 32-byte cpu-visible transfer data buffer
// - region starts at first index
// - direction bit: 1 transmit, 0 receive
// - start flag begins; completion sets irq, clears
// - internal clock pulses only during transfer
// - data output holds last bit sent
// - external clock transmit stops after completion
// - idle level bit sets output between transfers
// - buffer access in transmit flags error
// - serial in select gates chip select enable
// - internal clock receive starts immediately
// - external receive samples only while busy
// - buffer access in receive sets overrun
// - internal clock transmit gap holds clock high at divisions
// - irq reaches cpu only when enabled
// - lsb first, out on fall, in on rise
// - busy buffer writes ignored, reads all ones
// - clearing start flag aborts transfer
// - start above end wraps through zero
package bssp_pkg;
   localparam int BUF_DEPTH = 32;
   localparam int IDX_W = 5;
   localparam logic [7:0] BUSY_READ_VALUE = 8'hff;
   localparam logic [1:0] GAP_NONE = 2'h0;
   localparam logic [1:0] GAP_ONE = 2'h1;
   localparam logic [1:0] GAP_TWO = 2'h2;
   localparam logic [3:0] GAP_EIGHT_CYCLES = 4'h8;
   // internal clock half period in system clocks per selected source
   localparam logic [7:0] HALF_DIV0 = 8'h02;
   localparam logic [7:0] HALF_DIV1 = 8'h08;
   localparam logic [7:0] HALF_DIV2 = 8'h20;
   typedef struct packed {
      logic transmit;
      logic [1:0] clock_source; // 3 = external
      logic [1:0] gap_length;
   } serial_control_s;
   typedef struct packed {
      logic serial_out_pin_select;
      logic serial_in_pin_select;
      logic open_drain_select;
      logic chip_select_select;
   } pin_mode_s;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LOW = 4'b0010,
      ST_HIGH = 4'b0100,
      ST_GAP = 4'b1000
   } shift_state_e;
endpackage

// File: core/bssp_core.sv
// buffered synchronous serial port core
`timescale 1ns/1ps
module bssp_core (
   // system
   input wire logic clock_in,
   input wire logic nrst_in,
   // cpu buffer port
   input wire logic buf_req_in,
   input wire logic buf_write_in,
   input wire logic [4:0] buf_index_in,
   input wire logic [7:0] buf_wdata_in,
   output logic [7:0] buf_rdata_out,
   // control
   input wire logic start_set_in,
   input wire logic start_clear_in,
   input wire logic [4:0] buffer_first_index_reg_in,
   input wire logic [4:0] buffer_last_index_reg_in,
   input wire bssp_pkg::serial_control_s serial_control_reg_in,
   input wire bssp_pkg::pin_mode_s pin_mode_in,
   input wire logic gap_interval_select_in,
   input wire logic idle_level_bit_in,
   input wire logic idle_level_write_in,
   input wire logic flag_clear_in,
   input wire logic transfer_irq_enable_in,
   // status
   output logic start_busy_flag_out,
   output logic transfer_irq_flag_out,
   output logic buffer_access_error_flag_out,
   output logic overrun_flag_out,
   output logic irq_out,
   // pins
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_out,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_out,
   output logic chip_select_n_out,
   output logic chip_select_oe_out
);
   logic [7:0] buffer [0:bssp_pkg::BUF_DEPTH-1];
   bssp_pkg::shift_state_e state, next_state;
   logic busy, next_busy;
   logic [4:0] ptr, next_ptr;
   logic [2:0] bitn, next_bitn;
   logic byte_odd, next_byte_odd;
   logic [7:0] div, next_div;
   logic [3:0] gap_cnt, next_gap_cnt;
   logic dout, next_dout;
   logic sck, next_sck;
   logic irqf, next_irqf, werr, next_werr, overrun_flag, next_ovr;
   logic [7:0] rdata, next_rdata;
   logic sck_s1, sck_s2, sck_s3, din_s1, din_s2;
   logic ext, fall_ev, rise_ev, last_bit, done_byte, cpu_hit;
   logic [7:0] half;

   // link inputs pass two flops before use
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         sck_s1 <= serial_clock_pin_in;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         din_s1 <= serial_data_pin_in;
         din_s2 <= din_s1;
      end
   end

   always_comb begin
      ext = (serial_control_reg_in.clock_source == 2'h3);
      case (serial_control_reg_in.clock_source)
         2'h0: half = bssp_pkg::HALF_DIV0;
         2'h1: half = bssp_pkg::HALF_DIV1;
         default: half = bssp_pkg::HALF_DIV2;
      endcase
      last_bit = (bitn == 3'h7);
      done_byte = last_bit && (ptr == buffer_last_index_reg_in);
      cpu_hit = buf_req_in && busy;
   end

   // shift engine: internal clock counts halves, external uses synced edges
   always_comb begin
      next_state = state;
      next_busy = busy;
      next_ptr = ptr;
      next_bitn = bitn;
      next_byte_odd = byte_odd;
      next_div = div;
      next_gap_cnt = gap_cnt;
      next_dout = dout;
      next_sck = sck;
      fall_ev = 1'b0;
      rise_ev = 1'b0;
      if (!busy && idle_level_write_in) begin
         next_dout = idle_level_bit_in;
      end
      case (state)
         bssp_pkg::ST_IDLE: begin
            next_sck = 1'b1;
            if (start_set_in) begin
               next_busy = 1'b1;
               next_ptr = buffer_first_index_reg_in;
               next_bitn = 3'h0;
               next_byte_odd = 1'b0;
               next_div = 8'h00;
               next_state = bssp_pkg::ST_LOW;
               if (!ext) begin
                  fall_ev = 1'b1;
                  next_sck = 1'b0;
               end
            end
         end
         bssp_pkg::ST_LOW: begin
            if (ext) begin
               rise_ev = sck_s2 && !sck_s3;
               // an outside frame opens with a fall that must drive bit 0
               fall_ev = !sck_s2 && sck_s3;
            end else if (div == half - 8'h01) begin
               rise_ev = 1'b1;
               next_sck = 1'b1;
               next_div = 8'h00;
            end else begin
               next_div = div + 8'h01;
            end
            if (rise_ev) begin
               next_state = bssp_pkg::ST_HIGH;
               // an outside master stops after its last rise, so finish there
               if (ext && done_byte) begin
                  next_busy = 1'b0;
                  next_state = bssp_pkg::ST_IDLE;
               end
            end
         end
         bssp_pkg::ST_HIGH: begin
            if (ext) begin
               fall_ev = !sck_s2 && sck_s3;
            end else if (div == half - 8'h01) begin
               fall_ev = 1'b1;
               next_div = 8'h00;
            end else begin
               next_div = div + 8'h01;
            end
            if (fall_ev) begin
               next_bitn = bitn + 3'h1;
               next_sck = ext ? sck : 1'b0;
               next_state = bssp_pkg::ST_LOW;
               if (last_bit) begin
                  next_ptr = ptr + 5'h01;
                  next_byte_odd = !byte_odd;
                  if (done_byte) begin
                     next_busy = 1'b0;
                     next_sck = 1'b1;
                     next_state = bssp_pkg::ST_IDLE;
                  end else if (!ext && serial_control_reg_in.transmit &&
                        serial_control_reg_in.gap_length != bssp_pkg::GAP_NONE &&
                        (gap_interval_select_in || byte_odd)) begin
                     next_sck = 1'b1;
                     next_gap_cnt = 4'h0;
                     next_state = bssp_pkg::ST_GAP;
                  end
               end
            end
         end
         bssp_pkg::ST_GAP: begin
            if (div == half - 8'h01) begin
               next_div = 8'h00;
               next_gap_cnt = gap_cnt + 4'h1;
               if ((serial_control_reg_in.gap_length == bssp_pkg::GAP_ONE &&
                     gap_cnt == 4'h1) ||
                   (serial_control_reg_in.gap_length == bssp_pkg::GAP_TWO &&
                     gap_cnt == 4'h3) ||
                   (gap_cnt == 4'((5'(bssp_pkg::GAP_EIGHT_CYCLES) << 1) - 5'h01))) begin
                  fall_ev = 1'b1;
                  next_sck = 1'b0;
                  next_state = bssp_pkg::ST_LOW;
               end
            end else begin
               next_div = div + 8'h01;
            end
         end
         default: next_state = bssp_pkg::ST_IDLE;
      endcase
      if (fall_ev && serial_control_reg_in.transmit && next_busy) begin
         next_dout = buffer[next_ptr][next_bitn];
      end
      if (start_clear_in) begin
         next_busy = 1'b0;
         next_sck = 1'b1;
         next_state = bssp_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= bssp_pkg::ST_IDLE;
         busy <= 1'b0;
         ptr <= 5'h00;
         bitn <= 3'h0;
         byte_odd <= 1'b0;
         div <= 8'h00;
         gap_cnt <= 4'h0;
         dout <= 1'b1;
         sck <= 1'b1;
      end else begin
         state <= next_state;
         busy <= next_busy;
         ptr <= next_ptr;
         bitn <= next_bitn;
         byte_odd <= next_byte_odd;
         div <= next_div;
         gap_cnt <= next_gap_cnt;
         dout <= next_dout;
         sck <= next_sck;
      end
   end

   // buffer: no reset, cpu side blocked while busy
   always_ff @(posedge clock_in) begin
      if (buf_req_in && buf_write_in && !busy) begin
         buffer[buf_index_in] <= buf_wdata_in;
      end else if (rise_ev && !start_clear_in && !serial_control_reg_in.transmit) begin
         buffer[ptr][bitn] <= din_s2;
      end
   end

   // flags: set wins over clear
   always_comb begin
      next_irqf = irqf;
      next_werr = werr;
      next_ovr = overrun_flag;
      next_rdata = rdata;
      if (flag_clear_in) begin
         next_irqf = 1'b0;
         next_werr = 1'b0;
         next_ovr = 1'b0;
      end
      if (busy && !next_busy && !start_clear_in) begin
         next_irqf = 1'b1;
      end
      if (cpu_hit) begin
         next_irqf = 1'b1;
         next_werr = 1'b1;
         if (!serial_control_reg_in.transmit) begin
            next_ovr = 1'b1;
         end
      end
      if (buf_req_in && !buf_write_in) begin
         next_rdata = busy ? bssp_pkg::BUSY_READ_VALUE : buffer[buf_index_in];
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irqf <= 1'b0;
         werr <= 1'b0;
         overrun_flag <= 1'b0;
         rdata <= 8'h00;
      end else begin
         irqf <= next_irqf;
         werr <= next_werr;
         overrun_flag <= next_ovr;
         rdata <= next_rdata;
      end
   end

   always_comb begin
      buf_rdata_out = rdata;
      start_busy_flag_out = busy;
      transfer_irq_flag_out = irqf;
      buffer_access_error_flag_out = werr;
      overrun_flag_out = overrun_flag;
      irq_out = irqf && transfer_irq_enable_in;
      serial_clock_pin_out = sck;
      serial_clock_pin_oe_out = !ext;
      serial_data_pin_out = pin_mode_in.open_drain_select ? 1'b0 : dout;
      // open drain only pulls low
      serial_data_pin_oe_out = pin_mode_in.serial_out_pin_select &&
         (!pin_mode_in.open_drain_select || !dout);
      chip_select_n_out = !busy;
      chip_select_oe_out = pin_mode_in.serial_in_pin_select &&
         pin_mode_in.chip_select_select && serial_control_reg_in.transmit;
   end

   a_done_irq: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (busy && !next_busy && !start_clear_in) |=> irqf && !busy)
      else $error("completion did not set irq");
   a_busy_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (busy && buf_req_in && !buf_write_in) |=> buf_rdata_out == 8'hff)
      else $error("busy read not all ones");
   a_hit_flags: assert property (@(posedge clock_in) disable iff (!nrst_in)
      cpu_hit |=> werr && irqf)
      else $error("buffer hit flags missing");
   a_rx_overrun: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (cpu_hit && !serial_control_reg_in.transmit) |=> overrun_flag)
      else $error("overrun not set");
   a_irq_gate: assert property (@(posedge clock_in) disable iff (!nrst_in)
      irq_out |-> transfer_irq_enable_in && irqf)
      else $error("irq not gated");
   a_idle_clock: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !busy |=> sck || busy)
      else $error("clock pulse while idle");
   a_abort_stop: assert property (@(posedge clock_in) disable iff (!nrst_in)
      start_clear_in |=> !busy && state == bssp_pkg::ST_IDLE)
      else $error("abort ignored");
   a_hold_data: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (!busy && !idle_level_write_in && !start_set_in) |=> $stable(dout))
      else $error("idle data changed");
   a_start_ptr: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (!busy && start_set_in && !start_clear_in) |=> ptr == $past(buffer_first_index_reg_in))
      else $error("start index wrong");
   a_gap_high: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (state == bssp_pkg::ST_GAP) |-> sck)
      else $error("clock low during gap");
   c_tx_done: cover property (@(posedge clock_in) busy && serial_control_reg_in.transmit ##1 !busy);
   c_rx_done: cover property (@(posedge clock_in) busy && !serial_control_reg_in.transmit ##1 !busy);
   c_gap: cover property (@(posedge clock_in) state == bssp_pkg::ST_GAP);
endmodule

// File: dv/bssp_peer.sv
// far-side serial peripheral model: captures the port's output, feeds its input
`timescale 1ns/1ps
module bssp_peer (
   // serial wires
   input wire logic sck_in,
   input wire logic dout_in,
   output logic din_out,
   // bench control
   input wire logic clr_in,
   input wire logic [63:0] tx_in
);
   logic [63:0] rx;
   int n;
   always @(posedge sck_in or posedge clr_in) begin
      if (clr_in) begin
         n <= 0;
      end else begin
         rx[n] <= dout_in;
         n <= n + 1;
      end
   end
   // stale data is inverted so an early sample cannot pass by luck
   always @(negedge sck_in or posedge clr_in) begin
      if (clr_in) begin
         din_out <= ~tx_in[0];
      end else begin
         din_out <= tx_in[n];
      end
   end
endmodule

// File: dv/buffered_sync_serial_port_test.sv
// self-checking bench for the buffered synchronous serial port
`timescale 1ns/1ps
// compare and count
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module buffered_sync_serial_port_test;
   logic clock_in, nrst_in, buf_req_in, buf_write_in, start_set_in, start_clear_in;
   logic gap_interval_select_in, idle_level_bit_in, idle_level_write_in, flag_clear_in;
   logic transfer_irq_enable_in, serial_clock_pin_in, serial_data_pin_in, ext_sck, peer_clr;
   logic [4:0] buf_index_in, buffer_first_index_reg_in, buffer_last_index_reg_in;
   logic [7:0] buf_wdata_in, buf_rdata_out;
   bssp_pkg::serial_control_s serial_control_reg_in;
   bssp_pkg::pin_mode_s pin_mode_in;
   logic start_busy_flag_out, transfer_irq_flag_out, buffer_access_error_flag_out;
   logic overrun_flag_out, irq_out, serial_clock_pin_out, serial_clock_pin_oe_out;
   logic serial_data_pin_out, serial_data_pin_oe_out, chip_select_n_out, chip_select_oe_out;
   logic dout_w;
   logic [63:0] tx;
   logic [7:0] mem [32];
   int miscompares, comparisons;
   assign serial_clock_pin_in = serial_clock_pin_oe_out ? serial_clock_pin_out : ext_sck;
   // pull-up on the data wire when the open drain lets go
   assign dout_w = serial_data_pin_oe_out ? serial_data_pin_out : 1'b1;
   bssp_core i_bssp_core (.clock_in, .nrst_in, .buf_req_in, .buf_write_in, .buf_index_in,
      .buf_wdata_in, .buf_rdata_out, .start_set_in, .start_clear_in,
      .buffer_first_index_reg_in, .buffer_last_index_reg_in, .serial_control_reg_in,
      .pin_mode_in, .gap_interval_select_in, .idle_level_bit_in, .idle_level_write_in,
      .flag_clear_in, .transfer_irq_enable_in, .start_busy_flag_out, .transfer_irq_flag_out,
      .buffer_access_error_flag_out, .overrun_flag_out, .irq_out, .serial_clock_pin_in,
      .serial_clock_pin_out, .serial_clock_pin_oe_out, .serial_data_pin_in,
      .serial_data_pin_out, .serial_data_pin_oe_out, .chip_select_n_out, .chip_select_oe_out);
   bssp_peer i_bssp_peer (.sck_in(serial_clock_pin_in), .dout_in(dout_w),
      .din_out(serial_data_pin_in), .clr_in(peer_clr), .tx_in(tx));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   // idle cycle after the pulse keeps back-to-back calls legal
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask
   task automatic bacc(input logic w, input logic [4:0] i, input logic [7:0] d);
      buf_write_in = w;
      buf_index_in = i;
      buf_wdata_in = d;
      pulse(buf_req_in);
   endtask
   task automatic start(input logic t, input logic [1:0] s, input logic [1:0] g,
      input logic [4:0] f, input logic [4:0] l);
      serial_control_reg_in = {t, s, g};
      buffer_first_index_reg_in = f;
      buffer_last_index_reg_in = l;
      pulse(peer_clr);
      pulse(start_set_in);
   endtask
   // link clock, phase unrelated to the system clock, still between frames
   task automatic extclk(input int n);
      repeat (n) begin
         #3 ext_sck = 1'b0;
         #80 ext_sck = 1'b1;
         #77;
      end
      cyc(1);
   endtask
   task automatic finish;
      int k;
      for (k = 0; k < 20000 && start_busy_flag_out !== 1'b0; k++) cyc(1);
      `CHK(start_busy_flag_out, 1'b0)
   endtask
   task automatic results;
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #400us;
      miscompares++;
      results();
   end
   initial begin
      void'($urandom(60702));
      {nrst_in, buf_req_in, buf_write_in, start_set_in, start_clear_in} = '0;
      {idle_level_bit_in, idle_level_write_in, flag_clear_in, transfer_irq_enable_in} = '0;
      {buf_index_in, buf_wdata_in, buffer_first_index_reg_in, buffer_last_index_reg_in} = '0;
      serial_control_reg_in = '0;
      pin_mode_in = '0;
      gap_interval_select_in = 1'b1;
      {ext_sck, peer_clr, tx} = {1'b1, 1'b0, 64'h0};
      cyc(3);
      nrst_in = 1'b1;
      `CHK(start_busy_flag_out, 1'b0)
      `CHK(serial_clock_pin_out, 1'b1)
      transfer_irq_enable_in = 1'b1;
      pulse(start_clear_in);
      for (int i = 0; i < 32; i++) begin
         mem[i] = 8'($urandom);
         bacc(1'b1, i[4:0], mem[i]);
      end
      for (int i = 0; i < 32; i++) begin
         bacc(1'b0, i[4:0], 8'h00);
         `CHK(buf_rdata_out, mem[i])
      end
      pin_mode_in = 4'h8;
      start(1'b1, 2'h0, 2'h0, 5'h1e, 5'h01);
      finish();
      for (int i = 0; i < 4; i++) `CHK(i_bssp_peer.rx[8*i+:8], mem[(30+i)%32])
      `CHK(i_bssp_peer.n, 32)
      `CHK(transfer_irq_flag_out, 1'b1)
      `CHK(irq_out, 1'b1)
      `CHK(serial_data_pin_out, mem[1][7])
      cyc(40);
      `CHK(i_bssp_peer.n, 32)
      transfer_irq_enable_in = 1'b0;
      cyc(1);
      `CHK(irq_out, 1'b0)
      transfer_irq_enable_in = 1'b1;
      pulse(flag_clear_in);
      pin_mode_in = 4'ha;
      for (int v = 0; v < 2; v++) begin
         idle_level_bit_in = v[0];
         pulse(idle_level_write_in);
         `CHK(dout_w, v[0])
         `CHK(serial_data_pin_oe_out, ~v[0])
      end
      pin_mode_in = 4'hd;
      start(1'b1, 2'h1, 2'h3, 5'h00, 5'h03);
      `CHK(chip_select_oe_out, 1'b1)
      `CHK(chip_select_n_out, 1'b0)
      bacc(1'b1, 5'h00, ~mem[0]);
      bacc(1'b0, 5'h02, 8'h00);
      `CHK(buf_rdata_out, 8'hff)
      `CHK(buffer_access_error_flag_out, 1'b1)
      `CHK(overrun_flag_out, 1'b0)
      finish();
      for (int i = 0; i < 4; i++) `CHK(i_bssp_peer.rx[8*i+:8], mem[i])
      bacc(1'b0, 5'h00, 8'h00);
      `CHK(buf_rdata_out, mem[0])
      pin_mode_in = 4'h8;
      start(1'b1, 2'h3, 2'h0, 5'h05, 5'h05);
      `CHK(serial_clock_pin_oe_out, 1'b0)
      extclk(8);
      finish();
      extclk(8);
      `CHK(i_bssp_peer.rx[7:0], mem[5])
      `CHK(dout_w, mem[5][7])
      pin_mode_in = 4'h4;
      for (int e = 0; e < 2; e++) begin
         tx = {$urandom, $urandom};
         pulse(flag_clear_in);
         start(1'b0, e ? 2'h3 : 2'h2, 2'h0, 5'h07, 5'h08);
         extclk(8 * e);
         bacc(1'b0, 5'h00, 8'h00);
         `CHK(overrun_flag_out, 1'b1)
         extclk(8 * e);
         finish();
         extclk(8 * e);
         for (int j = 0; j < 2; j++) begin
            bacc(1'b0, 5'h07 + j[4:0], 8'h00);
            `CHK(buf_rdata_out, tx[8*j+:8])
         end
         bacc(1'b0, 5'h09, 8'h00);
         `CHK(buf_rdata_out, mem[9])
      end
      pin_mode_in = 4'h8;
      pulse(flag_clear_in);
      start(1'b1, 2'h2, 2'h0, 5'h00, 5'h1f);
      cyc(100);
      pulse(start_clear_in);
      `CHK(start_busy_flag_out, 1'b0)
      `CHK(transfer_irq_flag_out, 1'b0)
      bacc(1'b0, 5'h00, 8'h00);
      `CHK(buf_rdata_out, mem[0])
      results();
   end
endmodule
